// [verilog/twm_pkg.sv]
/*
  Package for the two-wire master bus engine: timing constants, field widths,
  bus-line reset levels and the engine's state encoding.
  Assumes a 200 MHz clock on every module that imports it.
*/
package twm_pkg;
  // Clock period and spike filter figures
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SPIKE_NS = 50;
  localparam int SPIKE_CYC = (SPIKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Bit rate generator: period = BASE + 2 * divisor * 4**prescale
  localparam int SCL_BASE_CYC = 16;
  localparam int DIV_W = 8;
  localparam int PS_W = 2;
  localparam int CNT_W = 24;
  localparam int PKT_BITS = 9;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic LINE_IDLE = 1'b1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;

  // Engine states, one-hot
  typedef enum logic [7:0] {
    TWM_IDLE  = 8'h01,
    TWM_START = 8'h02,
    TWM_LOW   = 8'h04,
    TWM_HIGH  = 8'h08,
    TWM_STOP1 = 8'h10,
    TWM_STOP2 = 8'h20,
    TWM_SLAVE = 8'h40,
    TWM_RSTRT = 8'h80
  } twm_state_type;
endpackage

// [verilog/twm_filter.sv]
/*
  Input conditioner for one open-drain bus line: two-flop synchroniser followed
  by a spike filter that only accepts a new level once it has held steady.
  Assumes the raw line comes straight from a pad, asynchronous to clk_i.
*/
`timescale 1ns/1ps
module twm_filter #(
  parameter int HOLD_CYC = twm_pkg::SPIKE_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Line in and filtered level out
  input wire logic line_i,
  output logic line_o
);
  import twm_pkg::*;

  logic sync1;
  logic sync2;
  logic [7:0] stable_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Two flops before anything looks at the pad
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sync1 <= LINE_IDLE;
      sync2 <= LINE_IDLE;
    end else begin
      sync1 <= line_i;
      sync2 <= sync1;
    end
  end

  // Accept a change only after it held for the spike window
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      stable_cnt <= 8'h00;
      line_o <= LINE_IDLE;
    end else if (sync2 == line_o) begin
      stable_cnt <= 8'h00;
    end else if (stable_cnt >= 8'(HOLD_CYC - 1)) begin
      stable_cnt <= 8'h00;
      line_o <= sync2;
    end else begin
      stable_cnt <= stable_cnt + 8'h01;
    end
  end
endmodule // twm_filter

// [verilog/twm_engine.sv]
/*
  Master-side bus engine for a two-wire interface: START, nine-bit packets,
  STOP and repeated START, clock stretching, clock synchronisation, arbitration
  with fall back to slave listening, and the bit rate generator.
  Assumes a user that offers one byte at a time and open-drain pads outside.
*/
// Function
// - Transfer is START, address with direction, one or more data bytes, then STOP.
// - STOP never follows START directly; an empty message is not allowed.
// - Slave may stretch SCL low; master waits for the line to rise.
// - Master alone times the SCL high phase, unaffected by stretching.
// - High count starts on seen-high line, low count on seen-low line.
// - After each driven bit sample SDA; released high but read low loses.
// - On loss stop transmitting at once and listen as a slave.
// - After loss keep SDA released; clocking may continue to packet end.
// - Arbitration is checked on every driven bit, data bytes included; the code skips the check on the ninth (acknowledge) bit.
// - Contention leaves bits seen by slaves intact; winner proceeds unaffected.
// - Bus inputs reject glitches shorter than 50 ns.
// - SCL period is 16 plus twice divisor times four to the prescale.
// - Slave listening ignores divisor and prescale; clock must be 16x SCL.
// - SDA changes only while SCL is low, except for START and STOP.
// - Packets are nine bits MSB first; ninth bit is the acknowledge.
`timescale 1ns/1ps
module twm_engine #(
  parameter int DIV_WIDTH = twm_pkg::DIV_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Bit rate settings
  input wire logic [DIV_WIDTH-1:0] bit_rate_divisor_i,
  input wire logic [twm_pkg::PS_W-1:0] bit_rate_prescale_i,
  // Byte command port
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic cmd_start_i,
  input wire logic cmd_stop_i,
  input wire logic [7:0] cmd_byte_i,
  input wire logic cmd_ack_i,
  output logic done_o,
  output logic [7:0] rx_byte_o,
  output logic rx_ack_o,
  output logic arb_lost_o,
  input wire logic arb_clear_i,
  output logic busy_o,
  // Open-drain bus pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);
  import twm_pkg::*;

  twm_state_type state;
  logic scl_f;
  logic sda_f;
  logic scl_prev;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] half_cyc;
  logic [3:0] bit_idx;
  logic [8:0] shift;
  logic [8:0] rx_shift;
  logic stop_pend;
  logic byte_cnt;
  logic scl_drive_low;
  logic sda_drive_low;
  logic sda_hold;
  logic hold_low;

  // Half period of SCL in clock cycles, rounded so high + low = full period
  function automatic logic [CNT_W-1:0] half_period(input logic [DIV_WIDTH-1:0] dv,
                                                   input logic [PS_W-1:0] ps);
    logic [CNT_W-1:0] scaled;
    scaled = CNT_W'(dv) << (2 * ps);
    return CNT_W'(SCL_BASE_CYC / 2) + scaled;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Filtered bus inputs
  twm_filter u_scl_filt (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .line_i(scl_i),
    .line_o(scl_f)
  );
  twm_filter u_sda_filt (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .line_i(sda_i),
    .line_o(sda_f)
  );

  assign half_cyc = half_period(bit_rate_divisor_i, bit_rate_prescale_i);

  ////////////////////////////////////////////////////////////////////////////
  // Previous filtered SCL for edge detection
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      scl_prev <= LINE_IDLE;
    end else begin
      scl_prev <= scl_f;
    end
  end

  // Phase counter; restarts whenever the wired line changes level
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt <= CNT_ZERO;
    end else if (scl_f != scl_prev) begin
      cnt <= CNT_ZERO;
    end else if (state == TWM_IDLE || state == TWM_SLAVE) begin
      cnt <= CNT_ZERO;
    end else if (state == TWM_HIGH && !scl_f) begin
      cnt <= CNT_ZERO;
    end else if (cnt >= half_cyc - 1) begin
      cnt <= CNT_ZERO;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequencer
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state <= TWM_IDLE;
      bit_idx <= 4'h0;
      shift <= 9'h1FF;
      rx_shift <= 9'h000;
      stop_pend <= 1'b0;
      byte_cnt <= 1'b0;
      scl_drive_low <= 1'b0;
      sda_drive_low <= 1'b0;
      done_o <= 1'b0;
      rx_byte_o <= 8'h00;
      rx_ack_o <= 1'b1;
      hold_low <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (state)
        TWM_IDLE: begin
          scl_drive_low <= 1'b0;
          sda_drive_low <= 1'b0;
          byte_cnt <= 1'b0;
          hold_low <= 1'b0;
          if (cmd_valid_i && cmd_start_i && scl_f && sda_f) begin
            state <= TWM_START;
            shift <= {cmd_byte_i, 1'b1};
            stop_pend <= cmd_stop_i;
          end
        end
        TWM_START, TWM_RSTRT: begin
          // SDA falls while SCL high, then SCL falls after a half period
          // A repeated START first waits for SCL to be seen high again
          if (state == TWM_START || scl_f) begin
            sda_drive_low <= 1'b1;
          end
          if (sda_drive_low && cnt >= half_cyc - 1) begin
            scl_drive_low <= 1'b1;
            bit_idx <= 4'h0;
            byte_cnt <= 1'b0;
            state <= TWM_LOW;
          end
        end
        TWM_LOW: begin
          // Data changes only in the low phase
          sda_drive_low <= ~shift[8];
          if (scl_drive_low && cnt >= half_cyc - 1) begin
            scl_drive_low <= 1'b0;
          end else if (!scl_drive_low && scl_f) begin
            state <= TWM_HIGH;
          end
        end
        TWM_HIGH: begin
          if (!scl_f && scl_prev) begin
            // Another master pulled SCL low first; follow it
            scl_drive_low <= 1'b1;
          end
          if (cnt == 1 && scl_f && !hold_low) begin
            rx_shift <= {rx_shift[7:0], sda_f};
            if (shift[8] && !sda_f && bit_idx != BIT_LAST) begin
              state <= TWM_SLAVE;
              sda_drive_low <= 1'b0;
              scl_drive_low <= 1'b0;
            end
          end
          if (hold_low || cnt >= half_cyc - 1 || (!scl_f && scl_prev)) begin
            scl_drive_low <= 1'b1;
            if (bit_idx == BIT_LAST) begin
              // Packet results are reported once, not again while waiting
              if (!hold_low) begin
                done_o <= 1'b1;
                rx_byte_o <= rx_shift[8:1];
                rx_ack_o <= sda_f;
              end
              byte_cnt <= 1'b1;
              if (!hold_low && stop_pend && byte_cnt) begin
                state <= TWM_STOP1;
              end else if (cmd_valid_i && cmd_start_i && byte_cnt) begin
                shift <= {cmd_byte_i, 1'b1};
                stop_pend <= cmd_stop_i;
                state <= TWM_RSTRT;
                hold_low <= 1'b0;
                sda_drive_low <= 1'b0;
                scl_drive_low <= 1'b0;
              end else if (cmd_valid_i) begin
                shift <= {cmd_byte_i, cmd_ack_i};
                stop_pend <= cmd_stop_i;
                bit_idx <= 4'h0;
                hold_low <= 1'b0;
                state <= TWM_LOW;
              end else begin
                // No byte offered yet: hold SCL low as back-pressure
                bit_idx <= BIT_LAST;
                hold_low <= 1'b1;
                state <= TWM_HIGH;
                scl_drive_low <= 1'b1;
              end
            end else begin
              shift <= {shift[7:0], 1'b1};
              bit_idx <= bit_idx + 4'h1;
              state <= TWM_LOW;
            end
          end
        end
        TWM_STOP1: begin
          // SDA low, then release SCL
          sda_drive_low <= 1'b1;
          if (cnt >= half_cyc - 1) begin
            scl_drive_low <= 1'b0;
            if (scl_f) begin
              state <= TWM_STOP2;
            end
          end
        end
        TWM_STOP2: begin
          // SDA rises while SCL high
          if (cnt >= half_cyc - 1) begin
            sda_drive_low <= 1'b0;
            state <= TWM_IDLE;
          end
        end
        TWM_SLAVE: begin
          // Listen only; leave bus released until STOP is seen
          sda_drive_low <= 1'b0;
          scl_drive_low <= 1'b0;
          if (scl_f && sda_f && !sda_hold) begin
            state <= TWM_IDLE;
          end
        end
        default: begin
          state <= TWM_IDLE;
        end
      endcase
    end
  end

  // Previous SDA for STOP detection while listening
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sda_hold <= LINE_IDLE;
    end else begin
      sda_hold <= sda_f;
    end
  end

  // Sticky arbitration-lost flag; a new loss wins over a clear
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      arb_lost_o <= 1'b0;
    end else if (state == TWM_SLAVE) begin
      arb_lost_o <= 1'b1;
    end else if (arb_clear_i) begin
      arb_lost_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins: open drain, only ever drive low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = scl_drive_low;
  assign sda_oe_o = sda_drive_low;
  assign busy_o = (state != TWM_IDLE);
  // A byte is accepted at packet end unless a STOP is due, or when starting from idle
  assign cmd_ready_o = (state == TWM_IDLE && scl_f && sda_f && cmd_start_i) ||
                       (state == TWM_HIGH && bit_idx == BIT_LAST &&
                        (hold_low || cnt >= half_cyc - 1 || (!scl_f && scl_prev)) &&
                        !(stop_pend && byte_cnt && !hold_low));
endmodule // twm_engine

// [test/twm_engine_monitor.sv]
/*
  Checker for the two-wire bus engine, bound to its ports.
  Assumes the pad inputs carry the wired-AND line levels.
*/
`timescale 1ns/1ps
module twm_engine_monitor #(
  parameter int DIV_WIDTH = twm_pkg::DIV_W
) (
  // Clock, reset and settings
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [DIV_WIDTH-1:0] bit_rate_divisor_i,
  input wire logic [twm_pkg::PS_W-1:0] bit_rate_prescale_i,
  // Command side
  input wire logic done_o,
  input wire logic [7:0] rx_byte_o,
  input wire logic arb_lost_o,
  input wire logic arb_clear_i,
  input wire logic busy_o,
  // Bus pins
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic sda_o,
  input wire logic sda_oe_o
);
  import twm_pkg::*;
  logic [15:0] hi_cnt;
  logic [15:0] half_cyc;
  // Expected half period; the filter delay only ever lengthens it
  assign half_cyc = 16'(SCL_BASE_CYC / 2) + (16'(bit_rate_divisor_i) << (2 * bit_rate_prescale_i));
  // Cycles the pad line has stood high, saturating
  always_ff @(posedge clk_i) begin
    if (!nrst_i || !scl_i) begin
      hi_cnt <= 16'h0000;
    end else if (hi_cnt != 16'hFFFF) begin
      hi_cnt <= hi_cnt + 16'h0001;
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  pins_low_a: assert property (scl_o == 1'h0 && sda_o == 1'h0)
    else $error("bus pin driven high");
  high_phase_a: assert property ($rose(scl_oe_o) && $past(scl_i) |-> hi_cnt >= half_cyc)
    else $error("SCL high phase cut short");
  loss_cause_a: assert property ($rose(arb_lost_o) |-> $past(sda_oe_o) == 1'h0)
    else $error("loss while driving SDA");
  loss_release_a: assert property ($rose(arb_lost_o) |-> !sda_oe_o [*8])
    else $error("SDA driven after loss");
  loss_sticky_a: assert property (arb_lost_o && !arb_clear_i |=> arb_lost_o)
    else $error("loss flag dropped");
  loss_clear_a: assert property (arb_clear_i && !busy_o |=> !arb_lost_o)
    else $error("loss flag not cleared");
  done_pulse_a: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  rx_hold_a: assert property ($changed(rx_byte_o) |-> ##[0:1] done_o)
    else $error("received byte moved between packets");
  idle_quiet_a: assert property (!busy_o && !$past(busy_o) |-> !scl_oe_o && !sda_oe_o)
    else $error("line pulled while idle");
  cover property (done_o);
  cover property ($rose(arb_lost_o));
  cover property (!scl_i && !scl_oe_o && busy_o);
endmodule // twm_engine_monitor

bind twm_engine twm_engine_monitor #(.DIV_WIDTH(DIV_WIDTH)) twm_engine_monitor_inst (.clk_i, .nrst_i,
  .bit_rate_divisor_i, .bit_rate_prescale_i, .done_o, .rx_byte_o, .arb_lost_o, .arb_clear_i, .busy_o,
  .scl_i, .scl_o, .scl_oe_o, .sda_o, .sda_oe_o);

// [test/twm_bus_model.sv]
/*
  Far side of the bus: a slave that acknowledges each packet, may stretch
  SCL, and can act as a rival master holding SDA low.
  Assumes it sees the wired-AND line levels.
*/
`timescale 1ns/1ps
module twm_bus_model (
  // Clock and line levels
  input wire logic clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  // Behaviour controls
  input wire logic [7:0] stretch_i,
  input wire logic steal_i,
  // Pull-downs
  output logic scl_low_o,
  output logic sda_low_o
);
  logic scl_q = 1'h1;
  logic sda_q = 1'h1;
  logic ack = 1'h0;
  logic rival = 1'h0;
  logic [3:0] bits = 4'h0;
  logic [7:0] hold = 8'h00;
  assign sda_low_o = ack | rival;
  assign scl_low_o = hold != 8'h00;
  // START clears the count, each rising SCL counts a bit
  always @(posedge clk_i) begin
    scl_q <= scl_i;
    sda_q <= sda_i;
    if (scl_i && scl_q && sda_q && !sda_i) begin
      bits <= 4'h0;
    end else if (scl_i && !scl_q) begin
      bits <= (bits == 4'h9) ? 4'h1 : bits + 4'h1;
    end
  end
  // SDA is pulled low only after a falling SCL; a rival lets go as soon as steal_i drops
  always @(posedge clk_i) begin
    if (scl_q && !scl_i) begin
      ack <= bits == 4'h8;
      hold <= stretch_i;
    end else if (hold != 8'h00) begin
      hold <= hold - 8'h01;
    end
    rival <= steal_i && (rival || (scl_q && !scl_i));
  end
endmodule // twm_bus_model

// [test/tb_top.sv]
/*
  Testbench for the two-wire bus engine on pull-up lines with a slave model.
  Assumes the engine, its checker and the model are compiled first.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; $display("BAD %0t %0h %0h", $time, a, b); end end
module tb_top;
  import twm_pkg::*;
  localparam int H = SCL_BASE_CYC / 2 + 10;
  logic clk_i = 1'h0;
  logic nrst_i = 1'h0;
  logic cv = 1'h0, cs = 1'h0, cp = 1'h0, clr = 1'h0, steal = 1'h0;
  logic [7:0] cb = 8'hFF, stretch = 8'h00, rx;
  logic rdy, done, rack, lost, busy, scl_oe, sda_oe, ms, md;
  int err_total = 0, comparisons = 0, hi = 0, hi_last = 0, hi_ref = 0, n;
  wire scl = !(scl_oe | ms); // Pull-ups win unless someone pulls
  wire sda = !(sda_oe | md);
  always #2.5 clk_i = !clk_i;
  twm_engine twm_engine_inst (.clk_i, .nrst_i, .bit_rate_divisor_i(8'h0A), .bit_rate_prescale_i(2'h0),
    .cmd_valid_i(cv), .cmd_ready_o(rdy), .cmd_start_i(cs), .cmd_stop_i(cp), .cmd_byte_i(cb), .cmd_ack_i(1'h1),
    .done_o(done), .rx_byte_o(rx), .rx_ack_o(rack), .arb_lost_o(lost), .arb_clear_i(clr), .busy_o(busy),
    .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe));
  twm_bus_model twm_bus_model_inst (.clk_i, .scl_i(scl), .sda_i(sda), .stretch_i(stretch), .steal_i(steal),
    .scl_low_o(ms), .sda_low_o(md));
  // Length of the last SCL high phase during a transfer
  always @(posedge clk_i) begin
    if (scl) hi <= hi + 1;
    else begin
      if (hi != 0 && busy) hi_last <= hi;
      hi <= 0;
    end
  end
  ////////////////////////////////////////
  task automatic offer(input logic [7:0] b, input logic s, input logic p);
    @(posedge clk_i) #1;
    cb = b; cs = s; cp = p; cv = 1'h1;
    n = 0;
    do begin @(negedge clk_i); n++; end while (!rdy && n < 9000);
    @(posedge clk_i) #1 cv = 1'h0;
  endtask
  task automatic xfer(input logic [7:0] b, input logic s, input logic p);
    offer(b, s, p);
    n = 0;
    do begin @(negedge clk_i); n++; end while (!done && n < 9000);
    `CHK(rx, b)
    `CHK(rack, 1'h0)
  endtask
  task automatic idle();
    n = 0;
    do begin @(negedge clk_i); n++; end while (busy && n < 9000);
    `CHK({busy, scl, sda}, 3'h3)
  endtask
  task automatic t_write();
    xfer(8'hA4, 1'h1, 1'h1); // Stop held back until a data byte
    repeat (100) @(negedge clk_i);
    `CHK({busy, scl}, 2'h2)
    xfer(8'h5A, 1'h0, 1'h1);
    hi_ref = hi_last;
    `CHK(hi_last >= H && hi_last <= H + 16, 1'h1)
    idle();
    $display("write test ended");
  endtask
  task automatic t_stretch();
    stretch = 8'h3C;
    xfer(8'h4B, 1'h1, 1'h0);
    xfer(8'hC3, 1'h1, 1'h0); // Repeated START
    xfer(8'h81, 1'h0, 1'h1);
    `CHK(hi_last, hi_ref)
    stretch = 8'h00;
    idle();
    $display("stretch test ended");
  endtask
  task automatic t_arb();
    steal = 1'h1;
    offer(8'hA4, 1'h1, 1'h1);
    n = 0;
    do begin @(negedge clk_i); n++; end while (!lost && n < 9000);
    `CHK({lost, sda_oe}, 2'h2)
    steal = 1'h0;
    idle();
    `CHK(lost, 1'h1)
    @(posedge clk_i) #1 clr = 1'h1;
    @(posedge clk_i) #1 clr = 1'h0;
    `CHK(lost, 1'h0)
    $display("arbitration test ended");
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////
  // Watchdog, several times the expected run
  initial begin
    repeat (30000) @(posedge clk_i);
    err_total++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    #1 nrst_i = 1'h1;
    repeat (20) @(posedge clk_i);
    t_write();
    t_stretch();
    t_arb();
    end_of_test();
  end
endmodule // tb_top
